// *** shared/cir_pkg.sv ***
// Constants for the converter identification and mode register slice.
// Assumes a byte-wide register file reached over a simple parallel port.
package cir_pkg;

  // Register addresses within the serial register space.
  localparam logic [6:0] ADDR_CLASS = 7'h03;
  localparam logic [6:0] ADDR_PART_LO = 7'h04;
  localparam logic [6:0] ADDR_PART_HI = 7'h05;
  localparam logic [6:0] ADDR_REVISION = 7'h06;
  localparam logic [6:0] ADDR_MAKER_LO = 7'h0C;
  localparam logic [6:0] ADDR_MAKER_HI = 7'h0D;
  localparam logic [6:0] ADDR_LEVELS = 7'h10;
  localparam logic [6:0] ADDR_MODE1 = 7'h12;

  // Fixed class code in the low nibble; the nibble above reads as zero.
  localparam logic [3:0] CLASS_CODE = 4'h3;

  // Reset values of the writable registers.
  localparam logic [7:0] LEVELS_RESET = 8'h01;
  localparam logic [7:0] MODE1_RESET = 8'hC1;

  // Field positions.
  localparam int LEVEL_LSB = 0;
  localparam int FORMAT_BIT = 7;
  localparam int CM_LSB = 5;
  localparam int GATE_BIT = 2;

  // Fixed pattern the host keeps in the low reserved bits of mode register one.
  localparam logic [1:0] MODE1_LOW_PATTERN = 2'h1;

  // Output level codes.
  localparam logic [1:0] LEVEL_1V2 = 2'h0;
  localparam logic [1:0] LEVEL_3V0 = 2'h1;
  localparam logic [1:0] LEVEL_RSVD = 2'h2;
  localparam logic [1:0] LEVEL_1V8 = 2'h3;

  // Host command port register addresses.
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_ADDR = 4'h1;
  localparam logic [3:0] HREG_WDATA = 4'h2;
  localparam logic [3:0] HREG_STATUS = 4'h3;
  localparam logic [3:0] HREG_RDATA = 4'h4;

endpackage : cir_pkg

// *** shared/cir_link_if.sv ***
// Register access link between the converter register bank and its host.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cir_link_if;
  logic [6:0] addr; // Register address.
  logic [7:0] wdata; // Write data.
  logic wr; // One-cycle write strobe.
  logic rd; // One-cycle read strobe.
  logic [7:0] rdata; // Read data, valid the cycle after rd.

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : cir_link_if

// *** design/cir_regbank.sv ***
// Converter identification and first operating-mode register bank.
// Assumes the link strobes come from logic on the same clock.
//
// Operation
// - Host writes zero to class upper nibble.
// - Class low nibble reads fixed code.
// - Part identifier: low byte, then high.
// - Version register reads fixed version code.
// - Maker code: low byte, then high.
// - Host writes zero to level reserved bits.
// - Level field selects serial output voltage.
// - Non-3V host sets level before reading.
// - Format bit: offset binary or two's complement.
// - Common-mode field selects reference range.
// - Host writes zero to mode bits 4:3.
// - Gate bit blocks or passes reference input.
// - Host writes 01 to mode bits 1:0.
`timescale 1ns/1ps
module cir_regbank #(
  parameter logic [15:0] PART_ID = 16'h00A5, // Arbitrary value.
  parameter logic [7:0] REVISION = 8'h00, // Arbitrary value.
  parameter logic [15:0] MAKER_ID = 16'h0ABC // Arbitrary value.
) (
  input wire logic clk, // 50 MHz clock.
  input wire logic rst, // Synchronous reset, active high.
  cir_link_if.dev link, // Register access link.
  input wire logic ref_in, // Timing reference pulse input.
  output logic [1:0] serial_output_level, // Serial output level code.
  output logic sample_format_select, // 1 = two's complement.
  output logic [1:0] reference_common_mode_range, // Receiver range code.
  output logic reference_gate_enable, // Reference detection enabled.
  output logic ref_detect // Gated, synchronised reference.
);

  logic [7:0] levels_reg;
  logic [7:0] mode1_reg;
  logic [7:0] rdata_reg;
  logic [1:0] ref_sync_reg;
  logic ref_detect_reg;
  logic [7:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; identification values are constants, so writes cannot
  // touch them.
  assign rd_mux =
    (link.addr == cir_pkg::ADDR_CLASS) ? {4'h0, cir_pkg::CLASS_CODE} :
    (link.addr == cir_pkg::ADDR_PART_LO) ? PART_ID[7:0] :
    (link.addr == cir_pkg::ADDR_PART_HI) ? PART_ID[15:8] :
    (link.addr == cir_pkg::ADDR_REVISION) ? REVISION :
    (link.addr == cir_pkg::ADDR_MAKER_LO) ? MAKER_ID[7:0] :
    (link.addr == cir_pkg::ADDR_MAKER_HI) ? MAKER_ID[15:8] :
    (link.addr == cir_pkg::ADDR_LEVELS) ? levels_reg :
    (link.addr == cir_pkg::ADDR_MODE1) ? mode1_reg : 8'h00;

  assign link.rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers; only the level and mode registers store writes.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      levels_reg <= cir_pkg::LEVELS_RESET;
      mode1_reg <= cir_pkg::MODE1_RESET;
    end
    else if (link.wr)
    begin
      if (link.addr == cir_pkg::ADDR_LEVELS)
        levels_reg <= link.wdata;
      if (link.addr == cir_pkg::ADDR_MODE1)
        mode1_reg <= link.wdata;
    end
  end

  // Read data stands for one cycle after the read strobe.
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= link.rd ? rd_mux : 8'h00;
  end

  // Reference input passes two flip-flops, then the gate, then a third flip-flop.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ref_sync_reg <= 2'h0;
      ref_detect_reg <= 1'b0;
    end
    else
    begin
      ref_sync_reg <= {ref_sync_reg[0], ref_in};
      ref_detect_reg <= ref_sync_reg[1] & mode1_reg[cir_pkg::GATE_BIT];
    end
  end

  // Configuration outputs come straight from the registers.
  assign serial_output_level = levels_reg[cir_pkg::LEVEL_LSB +: 2];
  assign sample_format_select = mode1_reg[cir_pkg::FORMAT_BIT];
  assign reference_common_mode_range = mode1_reg[cir_pkg::CM_LSB +: 2];
  assign reference_gate_enable = mode1_reg[cir_pkg::GATE_BIT];
  assign ref_detect = ref_detect_reg;

endmodule : cir_regbank

// *** design/cir_host.sv ***
// Host end: takes orders over a software port and runs single accesses
// on the link. Assumes the register bank shares this clock.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module cir_host (
  input wire logic clk, // 50 MHz clock.
  input wire logic rst, // Synchronous reset, active high.
  cir_link_if.host link, // Register access link.
  input wire logic [3:0] sw_addr, // Command port address.
  input wire logic [7:0] sw_wdata, // Command port write data.
  input wire logic sw_wr, // Command port write strobe.
  input wire logic sw_rd, // Command port read strobe.
  output logic [7:0] sw_rdata // Read data, one cycle after sw_rd.
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CAPT = 3'b100
  } cir_state_t;

  cir_state_t state_reg;
  logic [6:0] addr_reg;
  logic [7:0] wdata_reg;
  logic [7:0] rdata_reg;
  logic wr_reg;
  logic rd_reg;
  logic level_set_reg;
  logic refused_reg;
  logic [7:0] sw_rdata_reg;
  logic [7:0] wdata_fixed;
  logic cmd_go;
  logic cmd_write;
  logic read_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode: bit 0 writes, bit 1 reads, bit 2 says the link is 3 V.
  assign cmd_go = sw_wr && (sw_addr == cir_pkg::HREG_CMD) && (state_reg == ST_IDLE);
  assign cmd_write = sw_wdata[0];
  assign read_ok = sw_wdata[2] | level_set_reg;

  // Reserved bits are forced to their required values on every write.
  assign wdata_fixed =
    (addr_reg == cir_pkg::ADDR_CLASS) ? {4'h0, wdata_reg[3:0]} :
    (addr_reg == cir_pkg::ADDR_LEVELS) ? {6'h00, wdata_reg[1:0]} :
    (addr_reg == cir_pkg::ADDR_MODE1) ?
      {wdata_reg[7:5], 2'h0, wdata_reg[2], cir_pkg::MODE1_LOW_PATTERN} :
    wdata_reg;

  assign link.addr = addr_reg;
  assign link.wdata = wdata_fixed;
  assign link.wr = wr_reg;
  assign link.rd = rd_reg;
  assign sw_rdata = sw_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Software register writes.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_reg <= 7'h00;
      wdata_reg <= 8'h00;
    end
    else if (sw_wr && state_reg == ST_IDLE)
    begin
      if (sw_addr == cir_pkg::HREG_ADDR)
        addr_reg <= sw_wdata[6:0];
      if (sw_addr == cir_pkg::HREG_WDATA)
        wdata_reg <= sw_wdata;
    end
  end

  // Link sequencer: one strobe cycle, then capture read data if the access was a read.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      rdata_reg <= 8'h00;
      level_set_reg <= 1'b0;
      refused_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE:
        begin
          if (cmd_go && cmd_write)
          begin
            wr_reg <= 1'b1;
            refused_reg <= 1'b0;
            if (addr_reg == cir_pkg::ADDR_LEVELS)
              level_set_reg <= 1'b1;
            state_reg <= ST_WAIT;
          end
          else if (cmd_go && sw_wdata[1])
          begin
            refused_reg <= ~read_ok;
            if (read_ok)
            begin
              rd_reg <= 1'b1;
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT:
          state_reg <= rd_reg ? ST_CAPT : ST_IDLE;
        ST_CAPT:
        begin
          rdata_reg <= link.rdata;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Software read port.
  always_ff @(posedge clk)
  begin
    if (rst)
      sw_rdata_reg <= 8'h00;
    else if (sw_rd && sw_addr == cir_pkg::HREG_STATUS)
      sw_rdata_reg <= {5'h00, refused_reg, level_set_reg, state_reg != ST_IDLE};
    else if (sw_rd && sw_addr == cir_pkg::HREG_RDATA)
      sw_rdata_reg <= rdata_reg;
    else
      sw_rdata_reg <= 8'h00;
  end

endmodule : cir_host

// *** verif/cir_link_asserts.sv ***
// Checker for the link: identity bytes and readback.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module cir_link_asserts #(
  parameter logic [15:0] PART_ID = 16'h00A5, // Arbitrary.
  parameter logic [7:0] REVISION = 8'h00, // Arbitrary.
  parameter logic [15:0] MAKER_ID = 16'h0ABC // Arbitrary.
) (
  input wire logic clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic [6:0] addr, // Address.
  input wire logic [7:0] wdata, // Data in.
  input wire logic wr, // Write.
  input wire logic rd, // Read.
  input wire logic [7:0] rdata // Data out.
);
  logic [7:0] lv_reg;
  logic [7:0] om_reg;
  wire lv_hit = addr == cir_pkg::ADDR_LEVELS;
  wire om_hit = addr == cir_pkg::ADDR_MODE1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Shadows of the bytes written to the writable registers.
  always_ff @(posedge clk)
  begin
    lv_reg <= rst ? cir_pkg::LEVELS_RESET : wr && lv_hit ? wdata : lv_reg;
    om_reg <= rst ? cir_pkg::MODE1_RESET : wr && om_hit ? wdata : om_reg;
  end
  ////////////////////////////////////////
  // Read answers, one cycle after the strobe.
  property p_cls; rd && addr == 7'h03 |=> rdata == {4'h0, cir_pkg::CLASS_CODE}; endproperty
  a_cls: assert property (p_cls) else $error("Class byte wrong.");
  property p_plo; rd && addr == 7'h04 |=> rdata == PART_ID[7:0]; endproperty
  a_plo: assert property (p_plo) else $error("Part low byte wrong.");
  property p_phi; rd && addr == 7'h05 |=> rdata == PART_ID[15:8]; endproperty
  a_phi: assert property (p_phi) else $error("Part high byte wrong.");
  property p_rev; rd && addr == 7'h06 |=> rdata == REVISION; endproperty
  a_rev: assert property (p_rev) else $error("Version byte wrong.");
  property p_mlo; rd && addr == 7'h0C |=> rdata == MAKER_ID[7:0]; endproperty
  a_mlo: assert property (p_mlo) else $error("Maker low byte wrong.");
  property p_mhi; rd && addr == 7'h0D |=> rdata == MAKER_ID[15:8]; endproperty
  a_mhi: assert property (p_mhi) else $error("Maker high byte wrong.");
  property p_lv; rd && lv_hit |=> rdata == $past(lv_reg); endproperty
  a_lv: assert property (p_lv) else $error("Level readback wrong.");
  property p_om; rd && om_hit |=> rdata == $past(om_reg); endproperty
  a_om: assert property (p_om) else $error("Mode readback wrong.");
  // Reserved bits carry their required values on every write the host makes.
  property p_cls_wr; wr && addr == cir_pkg::ADDR_CLASS |-> wdata[7:4] == 4'h0; endproperty
  a_cls_wr: assert property (p_cls_wr) else $error("Class upper nibble not zero.");
  property p_lv_wr; wr && lv_hit |-> wdata[7:2] == 6'h00; endproperty
  a_lv_wr: assert property (p_lv_wr) else $error("Level reserved bits not zero.");
  property p_om_wr;
    wr && om_hit |-> wdata[4:3] == 2'h0 && wdata[1:0] == cir_pkg::MODE1_LOW_PATTERN;
  endproperty
  a_om_wr: assert property (p_om_wr) else $error("Mode reserved bits wrong.");
  // Read data stands only in the cycle after a read strobe.
  property p_idle; !rd |=> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("Read data outside its cycle.");
  // Main scenarios seen.
  c_lv: cover property (wr && lv_hit);
  c_om: cover property (rd && om_hit);
  c_id: cover property (rd && addr == 7'h0D);
endmodule : cir_link_asserts

// *** verif/cir_tb_top.sv ***
// Bench: host end and bank on one link, compared with a model.
// Assumes the package, link and both ends compile first.
`timescale 1ns/1ps
module converter_id_and_mode_registers_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] sw_addr = 4'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic ref_in = 1'b0;
  logic [7:0] sw_rdata, d, st, wd;
  logic [1:0] lvl, cm;
  logic fmt, gate, det;
  logic [7:0] mdl [0:127];
  logic [6:0] ads [0:15] = '{7'h03, 7'h04, 7'h05, 7'h06, 7'h0C, 7'h0D, 7'h08, 7'h7F,
    7'h10, 7'h10, 7'h10, 7'h10, 7'h12, 7'h12, 7'h12, 7'h12};
  integer seed = 32'h8F4F46E8;
  int n_mismatch = 0;
  int n_checks = 0;
  cir_link_if link ();
  // Free-running 50 MHz clock.
  always #10 clk = ~clk;
  cir_regbank cir_regbank_inst (.clk(clk), .rst(rst), .link(link.dev), .ref_in(ref_in),
    .serial_output_level(lvl), .sample_format_select(fmt),
    .reference_common_mode_range(cm), .reference_gate_enable(gate), .ref_detect(det));
  cir_host cir_host_inst (.clk(clk), .rst(rst), .link(link.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  cir_link_asserts cir_link_asserts_inst (.clk(clk), .rst(rst), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
  ////////////////////////////////////////
  // Counts a comparison and reports a difference.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One software port access; read data lands in d.
  task automatic sw(input logic [3:0] a, input logic [7:0] v, input logic w);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= w;
    sw_rd <= ~w;
    @(posedge clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    @(negedge clk);
    d = sw_rdata;
  endtask : sw
  // One link access ordered through the host, polled until idle.
  task automatic op(input logic [2:0] cmd, input logic [6:0] a, input logic [7:0] v);
    sw(cir_pkg::HREG_ADDR, {1'b0, a}, 1'b1);
    sw(cir_pkg::HREG_WDATA, v, 1'b1);
    sw(cir_pkg::HREG_CMD, {5'h00, cmd}, 1'b1);
    st = 8'hFF;
    for (int i = 0; i < 20 && st[0] !== 1'b0; i++)
    begin
      sw(cir_pkg::HREG_STATUS, 8'h00, 1'b0);
      st = d;
    end
    sw(cir_pkg::HREG_RDATA, 8'h00, 1'b0);
  endtask : op
  // Write through the host, update the model, compare the mode outputs.
  task automatic mwr(input logic [6:0] a, input logic [7:0] v);
    op(3'h1, a, v);
    if (a == cir_pkg::ADDR_LEVELS)
      mdl[a] = v & 8'h03;
    if (a == cir_pkg::ADDR_MODE1)
      mdl[a] = v & 8'hE4 | 8'h01;
    chk({6'h00, lvl}, mdl[16]);
    chk({fmt, cm, 2'h0, gate, 2'h1}, mdl[18]);
  endtask : mwr
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////
  // Main sequence.
  initial
  begin
    mdl = '{default: 8'h00};
    mdl[3] = {4'h0, cir_pkg::CLASS_CODE};
    mdl[4] = 8'hA5;
    mdl[12] = 8'hBC;
    mdl[13] = 8'h0A;
    mdl[16] = cir_pkg::LEVELS_RESET;
    mdl[18] = cir_pkg::MODE1_RESET;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Configuration outputs show the reset values before any write.
    @(negedge clk);
    chk({6'h00, lvl}, cir_pkg::LEVELS_RESET);
    chk({fmt, cm, 2'h0, gate, 2'h1}, cir_pkg::MODE1_RESET);
    // A low-voltage read before the level is set is refused.
    op(3'h2, cir_pkg::ADDR_PART_LO, 8'h00);
    chk({7'h00, st[2]}, 8'h01);
    // Write every place with random data, then read it back.
    for (int k = 0; k < 16; k++)
    begin
      wd = 8'($random(seed));
      if (k > 7 && k < 12)
        wd[1:0] = 2'(k);
      mwr(ads[k], wd);
      op(k > 8 ? 3'h2 : 3'h6, ads[k], 8'h00);
      chk(d, mdl[ads[k]]);
    end
    // The reference passes only while the gate is open.
    for (int g = 0; g < 2; g++)
    begin
      mwr(cir_pkg::ADDR_MODE1, {5'h00, 1'(g), 2'h1});
      @(posedge clk);
      ref_in <= 1'b1;
      repeat (4) @(posedge clk);
      ref_in <= 1'b0;
      @(negedge clk);
      chk({7'h00, det}, 8'(g));
    end
    tally_and_finish();
  end
  // Watchdog against a hang.
  initial
  begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : converter_id_and_mode_registers_tb_top
